/* File: rtl/rcf_regs.svh */
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH
// Frame constants
`define RCF_DELIM        8'h7e
`define RCF_REQ_TYPE     8'h17
`define RCF_RSP_TYPE     8'h97
`define RCF_RSVD_FILL    16'hfffe
`define RCF_FIXED_LEN    16'h000f
`define RCF_OFF_TYPE     16'h0003
`define RCF_OFF_FID      16'h0004
`define RCF_OFF_DEST     16'h0005
`define RCF_OFF_DEST_END 16'h000c
`define RCF_OFF_RSVD     16'h000d
`define RCF_OFF_OPT      16'h000f
`define RCF_OFF_CMD      16'h0010
`define RCF_OFF_PARAM    16'h0012
`define RCF_OFF_RSTAT    16'h0005
`define RCF_OFF_RVAL     16'h0006
`define RCF_RSP_HDR      8'h03
`define RCF_OPT_NOACK    0
`define RCF_OPT_APPLY    1
`define RCF_OPT_SECURE   4
`define RCF_OPT_MASK     8'h13
`define RCF_APPLY_CMD    16'h4143
`define RCF_HOST_PBYTES  3'h4
// Host register offsets
`define RCF_REG_CTRL     8'h00
`define RCF_REG_FID      8'h04
`define RCF_REG_DEST_HI  8'h08
`define RCF_REG_DEST_LO  8'h0c
`define RCF_REG_CMD      8'h10
`define RCF_REG_PARAM    8'h14
`define RCF_REG_PLEN     8'h18
`define RCF_REG_STATUS   8'h1c
`define RCF_REG_RVAL     8'h20
// Field positions
`define RCF_CTRL_START   0
`define RCF_ST_BUSY      0
`define RCF_ST_RVALID    1
`define RCF_ST_RERR      2
// Reset values
`define RCF_FID_RST      8'h01
`define RCF_DEST_RST     64'h0000_0000_0000_ffff
`endif

/* File: rtl/rcf_pkg.sv */
package rcf_pkg;
   typedef logic [7:0] rcf_byte_t;
   typedef enum {D_IDLE, D_LENH, D_LENL, D_BODY, D_CSUM, D_WAIT, D_RESP} rcf_dev_st_t;
   typedef enum {H_IDLE, H_SEND} rcf_host_tx_t;
endpackage : rcf_pkg

/* File: rtl/rcf_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rcf_link_if;
   logic              req_valid;
   logic              req_ready;
   rcf_pkg::rcf_byte_t req_data;
   logic              rsp_valid;
   logic              rsp_ready;
   rcf_pkg::rcf_byte_t rsp_data;
   modport host (output req_valid, input req_ready, output req_data,
                 input rsp_valid, output rsp_ready, input rsp_data);
   modport dev  (input req_valid, output req_ready, input req_data,
                 output rsp_valid, input rsp_ready, output rsp_data);
endinterface : rcf_link_if
`default_nettype wire

/* File: rtl/rcf_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
module rcf_host (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   rcf_link_if.host           link
);
   import rcf_pkg::*;
   rcf_host_tx_t tx_st_q;
   logic [7:0]  opt_q, fid_q, tx_b_q, tx_sum_q;
   logic [63:0] dest_q, dsh_q;
   logic [15:0] cmd_q, tx_idx_q, rx_idx_q, rx_len_q;
   logic [31:0] par_q, psh_q, rval_q, rsh_q;
   logic [2:0]  plen_q;
   logic [7:0]  rx_sum_q, rx_typ_q, rx_fid_q, rfid_q, rstat_q, rx_stat_q;
   logic        rvalid_q, rerr_q, rx_on_q;

   wire logic       wr_en    = psel && penable && pwrite;
   wire logic       hit_ctrl = paddr == `RCF_REG_CTRL;
   wire logic       mapped   = paddr <= `RCF_REG_RVAL && paddr[1:0] == 2'b00;
   wire logic       start    = wr_en && hit_ctrl && pwdata[`RCF_CTRL_START] && tx_st_q == H_IDLE;
   wire logic [15:0] tx_len  = `RCF_FIXED_LEN + {13'h0000, plen_q};
   wire logic [15:0] tx_last = tx_len + 16'h0003;
   wire logic       tx_take  = link.req_valid && link.req_ready;
   wire logic [15:0] nxt     = tx_idx_q + 16'h0001;
   wire logic [7:0] sum_nxt  = (tx_idx_q >= `RCF_OFF_TYPE) ? tx_sum_q + tx_b_q : tx_sum_q;
   wire logic       rx_take  = link.rsp_valid;
   wire rcf_byte_t  rb       = link.rsp_data;
   wire logic       rx_end   = rx_on_q && rx_idx_q == rx_len_q + 16'h0003;
   wire logic       rx_ok    = (8'hff - rx_sum_q) == rb && rx_typ_q == `RCF_RSP_TYPE;

   // Next outgoing byte for frame position p
   function automatic rcf_byte_t tx_byte(input logic [15:0] p, input logic [7:0] s);
      if (p == 16'h0001)                                   tx_byte = tx_len[15:8];
      else if (p == 16'h0002)                              tx_byte = tx_len[7:0];
      else if (p == `RCF_OFF_TYPE)                         tx_byte = `RCF_REQ_TYPE;
      else if (p == `RCF_OFF_FID)                          tx_byte = fid_q;
      else if (p >= `RCF_OFF_DEST && p <= `RCF_OFF_DEST_END) tx_byte = dsh_q[63:56];
      else if (p == `RCF_OFF_RSVD)                         tx_byte = 8'(`RCF_RSVD_FILL >> 8);
      else if (p == `RCF_OFF_RSVD + 16'h0001)              tx_byte = 8'(`RCF_RSVD_FILL & 16'h00ff);
      else if (p == `RCF_OFF_OPT)                          tx_byte = opt_q & `RCF_OPT_MASK;
      else if (p == `RCF_OFF_CMD)                          tx_byte = cmd_q[15:8];
      else if (p == `RCF_OFF_CMD + 16'h0001)               tx_byte = cmd_q[7:0];
      else if (p == tx_last)                               tx_byte = 8'hff - s;
      else                                                 tx_byte = psh_q[31:24];
   endfunction : tx_byte

   assign link.req_valid = tx_st_q == H_SEND;
   assign link.req_data  = tx_b_q;
   assign link.rsp_ready = 1'b1;
   assign pready         = 1'b1;
   assign pslverr        = psel && penable && !mapped;

   always_comb begin
      case (paddr)
         `RCF_REG_CTRL:    prdata = {16'h0000, opt_q, 8'h00};
         `RCF_REG_FID:     prdata = {24'h000000, fid_q};
         `RCF_REG_DEST_HI: prdata = dest_q[63:32];
         `RCF_REG_DEST_LO: prdata = dest_q[31:0];
         `RCF_REG_CMD:     prdata = {16'h0000, cmd_q};
         `RCF_REG_PARAM:   prdata = par_q;
         `RCF_REG_PLEN:    prdata = {29'h00000000, plen_q};
         `RCF_REG_STATUS:  prdata = {8'h00, rstat_q, rfid_q, 5'h00, rerr_q, rvalid_q, tx_st_q == H_SEND};
         `RCF_REG_RVAL:    prdata = rval_q;
         default:          prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_q  <= 8'h00;
         fid_q  <= `RCF_FID_RST;
         dest_q <= `RCF_DEST_RST;
         cmd_q  <= 16'h0000;
         par_q  <= 32'h00000000;
         plen_q <= 3'h0;
      end else if (wr_en) begin
         case (paddr)
            `RCF_REG_CTRL:    opt_q  <= pwdata[15:8];
            `RCF_REG_FID:     fid_q  <= pwdata[7:0];
            `RCF_REG_DEST_HI: dest_q[63:32] <= pwdata;
            `RCF_REG_DEST_LO: dest_q[31:0] <= pwdata;
            `RCF_REG_CMD:     cmd_q  <= pwdata[15:0];
            `RCF_REG_PARAM:   par_q  <= pwdata;
            `RCF_REG_PLEN:    plen_q <= (pwdata[2:0] > `RCF_HOST_PBYTES) ? `RCF_HOST_PBYTES : pwdata[2:0];
            default:          ;
         endcase
      end
   end

   // Transmit; config writes during a frame do not disturb it except opt/fid/cmd/plen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_q  <= H_IDLE;
         tx_idx_q <= 16'h0000;
         tx_b_q   <= 8'h00;
         tx_sum_q <= 8'h00;
         dsh_q    <= 64'h0;
         psh_q    <= 32'h0;
      end else if (start) begin
         tx_st_q  <= H_SEND;
         tx_idx_q <= 16'h0000;
         tx_b_q   <= `RCF_DELIM;
         tx_sum_q <= 8'h00;
         dsh_q    <= dest_q;
         psh_q    <= par_q << ({2'b00, `RCF_HOST_PBYTES - plen_q} * 8);
      end else if (tx_st_q == H_SEND && tx_take) begin
         tx_idx_q <= nxt;
         tx_sum_q <= sum_nxt;
         tx_b_q   <= tx_byte(nxt, sum_nxt);
         if (nxt >= `RCF_OFF_DEST && nxt <= `RCF_OFF_DEST_END)
            dsh_q <= dsh_q << 8;
         if (nxt >= `RCF_OFF_PARAM && nxt < tx_last)
            psh_q <= psh_q << 8;
         if (tx_idx_q == tx_last)
            tx_st_q <= H_IDLE;
      end
   end

   // Response receiver; a new response overwrites, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_on_q <= 1'b0;
         rx_idx_q <= 16'h0000;
         rx_len_q <= 16'h0000;
         rx_sum_q <= 8'h00;
         rx_typ_q <= 8'h00;
         rx_fid_q <= 8'h00;
         rx_stat_q <= 8'h00;
         rsh_q <= 32'h0;
         rvalid_q <= 1'b0;
         rerr_q <= 1'b0;
         rfid_q <= 8'h00;
         rstat_q <= 8'h00;
         rval_q <= 32'h0;
      end else begin
         if (wr_en && paddr == `RCF_REG_STATUS && pwdata[`RCF_ST_RVALID])
            rvalid_q <= 1'b0;
         if (wr_en && paddr == `RCF_REG_STATUS && pwdata[`RCF_ST_RERR])
            rerr_q <= 1'b0;
         if (rx_take) begin
            rx_idx_q <= rx_idx_q + 16'h0001;
            if (rx_idx_q >= `RCF_OFF_TYPE)
               rx_sum_q <= rx_sum_q + rb;
            if (!rx_on_q) begin
               rx_on_q <= rb == `RCF_DELIM;
               rx_idx_q <= 16'h0001;
               rx_sum_q <= 8'h00;
               rsh_q <= 32'h0;
            end else if (rx_end) begin
               rx_on_q <= 1'b0;
               if (rx_ok) rvalid_q <= 1'b1;
               else rerr_q <= 1'b1;
               if (rx_ok) begin
                  rfid_q <= rx_fid_q;
                  rstat_q <= rx_stat_q;
                  rval_q <= rsh_q;
               end
            end else if (rx_idx_q == 16'h0001) rx_len_q[15:8] <= rb;
            else if (rx_idx_q == 16'h0002) rx_len_q[7:0] <= rb;
            else if (rx_idx_q == `RCF_OFF_TYPE) rx_typ_q <= rb;
            else if (rx_idx_q == `RCF_OFF_FID) rx_fid_q <= rb;
            else if (rx_idx_q == `RCF_OFF_RSTAT) rx_stat_q <= rb;
            else rsh_q <= {rsh_q[23:0], rb};
         end
      end
   end
endmodule : rcf_host
`default_nettype wire

/* File: rtl/rcf_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
// Notes on behaviour
// - Frame opens with one delimiter byte
// - Length counts bytes between length and checksum
// - Offset 3 holds request type 0x17
// - Frame id echoed; zero suppresses response
// - Host puts 64-bit destination at offset 5
// - Reserved word ignored; host sends 0xFFFE
// - Option bit 0 disables acknowledgement; the device still sends the response and only drives req_no_ack
// - Option bit 1 applies now, else pending
// - Option bit 4 requests secure sending
// - Host zeroes all unused option bits
// - Two command characters at offset 16
// - Bytes from offset 18 are parameter value
// - No parameter bytes means query
// - Checksum is 0xFF minus body sum
// - Response type 0x97 echoes frame id
// - Password mode rejects plain requests; the device rejects every request, option bit 4 set or not
module rcf_device #(
   parameter int PMAX = 8
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   rcf_link_if.dev                   link,
   input  wire logic                 remote_command_password,
   output logic                      req_valid,
   output rcf_pkg::rcf_byte_t        req_fid,
   output logic [63:0]               req_dest,
   output rcf_pkg::rcf_byte_t        req_opt,
   output logic [15:0]               req_cmd,
   output logic [PMAX*8-1:0]         req_param,
   output logic [15:0]               req_plen,
   output logic                      req_query,
   output logic                      req_no_ack,
   output logic                      req_secure,
   output logic                      req_apply,
   output logic                      changes_pending,
   output logic                      frame_drop,
   output logic                      frame_reject,
   input  wire logic                 usr_done,
   input  wire rcf_pkg::rcf_byte_t   usr_status,
   input  wire logic [31:0]          usr_value,
   input  wire logic [2:0]           usr_vlen
);
   import rcf_pkg::*;
   localparam int PW = (PMAX > 1) ? $clog2(PMAX) : 1;

   rcf_dev_st_t st_q;
   logic [15:0] idx_q, len_q;
   rcf_byte_t   sum_q, typ_q, fid_q, opt_q, ob_q, rstat_q, rlen_q;
   logic [63:0] dest_q;
   logic [15:0] cmd_q;
   rcf_byte_t   par_q [PMAX];
   logic [31:0] rsh_q;
   logic        pend_q, drop_q, rej_q;

   wire logic        in_take   = link.req_valid && link.req_ready;
   wire rcf_byte_t   in_b      = link.req_data;
   wire logic [15:0] len_d     = {len_q[7:0], in_b};
   wire logic [15:0] len_max   = `RCF_FIXED_LEN + 16'(PMAX);
   wire logic        len_bad   = len_d < `RCF_FIXED_LEN || len_d > len_max;
   wire logic        last_body = idx_q == len_q + 16'h0002;
   wire logic [15:0] pos       = idx_q - `RCF_OFF_PARAM;
   wire logic        sum_ok    = (8'hff - sum_q) == in_b;
   wire logic        type_ok   = typ_q == `RCF_REQ_TYPE;
   wire logic        is_set    = len_q != `RCF_FIXED_LEN;
   wire logic        out_take  = link.rsp_valid && link.rsp_ready;
   wire logic [15:0] r_nxt     = idx_q + 16'h0001;
   wire logic [15:0] r_last    = {8'h00, rlen_q} + 16'h0003;
   wire rcf_byte_t   r_sum     = (idx_q >= `RCF_OFF_TYPE) ? sum_q + ob_q : sum_q;

   // Response byte at position p: delimiter, length, type, id, status, value, checksum
   function automatic rcf_byte_t rsp_byte(input logic [15:0] p, input rcf_byte_t s);
      if (p == 16'h0001)             rsp_byte = 8'h00;
      else if (p == 16'h0002)        rsp_byte = rlen_q;
      else if (p == `RCF_OFF_TYPE)   rsp_byte = `RCF_RSP_TYPE;
      else if (p == `RCF_OFF_FID)    rsp_byte = fid_q;
      else if (p == `RCF_OFF_RSTAT)  rsp_byte = rstat_q;
      else if (p == r_last)          rsp_byte = 8'hff - s;
      else                           rsp_byte = rsh_q[31:24];
   endfunction : rsp_byte

   assign link.req_ready  = st_q != D_WAIT && st_q != D_RESP;
   assign link.rsp_valid  = st_q == D_RESP;
   assign link.rsp_data   = ob_q;
   assign req_valid       = st_q == D_WAIT;
   assign req_fid         = fid_q;
   assign req_dest        = dest_q;
   assign req_opt         = opt_q;
   assign req_cmd         = cmd_q;
   assign req_plen        = len_q - `RCF_FIXED_LEN;
   assign req_query       = !is_set;
   assign req_no_ack      = opt_q[`RCF_OPT_NOACK];
   assign req_secure      = opt_q[`RCF_OPT_SECURE];
   assign req_apply       = opt_q[`RCF_OPT_APPLY] || cmd_q == `RCF_APPLY_CMD;
   assign changes_pending = pend_q;
   assign frame_drop      = drop_q;
   assign frame_reject    = rej_q;

   genvar g;
   generate
      for (g = 0; g < PMAX; g++) begin : g_par
         assign req_param[g*8 +: 8] = par_q[g];
      end
   endgenerate

   // Field capture while the body streams in
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         typ_q  <= 8'h00;
         fid_q  <= 8'h00;
         dest_q <= 64'h0;
         opt_q  <= 8'h00;
         cmd_q  <= 16'h0000;
         for (int i = 0; i < PMAX; i++) par_q[i] <= 8'h00;
      end else if (st_q == D_BODY && in_take) begin
         if (idx_q == `RCF_OFF_TYPE)
            typ_q <= in_b;
         if (idx_q == `RCF_OFF_FID)
            fid_q <= in_b;
         if (idx_q >= `RCF_OFF_DEST && idx_q <= `RCF_OFF_DEST_END)
            dest_q <= {dest_q[55:0], in_b};
         if (idx_q == `RCF_OFF_OPT)
            opt_q <= in_b;
         if (idx_q == `RCF_OFF_CMD || idx_q == `RCF_OFF_CMD + 16'h0001)
            cmd_q <= {cmd_q[7:0], in_b};
         if (idx_q >= `RCF_OFF_PARAM && pos < 16'(PMAX))
            par_q[pos[PW-1:0]] <= in_b;
      end
   end

   // Frame sequencing, checking and response
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= D_IDLE;
         idx_q   <= 16'h0000;
         len_q   <= 16'h0000;
         sum_q   <= 8'h00;
         ob_q    <= 8'h00;
         rstat_q <= 8'h00;
         rlen_q  <= 8'h00;
         rsh_q   <= 32'h0;
         pend_q  <= 1'b0;
         drop_q  <= 1'b0;
         rej_q   <= 1'b0;
      end else begin
         drop_q <= 1'b0;
         rej_q  <= 1'b0;
         case (st_q)
            D_IDLE: begin
               // Stray bytes outside a frame are skipped until a delimiter
               if (in_take && in_b == `RCF_DELIM)
                  st_q <= D_LENH;
               idx_q <= `RCF_OFF_TYPE;
               sum_q <= 8'h00;
            end
            D_LENH: if (in_take) begin
               len_q <= {8'h00, in_b};
               st_q  <= D_LENL;
            end
            D_LENL: if (in_take) begin
               len_q  <= len_d;
               drop_q <= len_bad;
               st_q   <= len_bad ? D_IDLE : D_BODY;
            end
            D_BODY: if (in_take) begin
               sum_q <= sum_q + in_b;
               idx_q <= idx_q + 16'h0001;
               if (last_body)
                  st_q <= D_CSUM;
            end
            D_CSUM: if (in_take) begin
               if (!sum_ok || !type_ok) begin
                  drop_q <= 1'b1;
                  st_q   <= D_IDLE;
               end else if (remote_command_password) begin
                  rej_q <= 1'b1;
                  st_q  <= D_IDLE;
               end else begin
                  st_q <= D_WAIT;
               end
            end
            D_WAIT: if (usr_done) begin
               if (req_apply)
                  pend_q <= 1'b0;
               else if (is_set)
                  pend_q <= 1'b1;
               rstat_q <= usr_status;
               rlen_q  <= `RCF_RSP_HDR + {5'h00, usr_vlen};
               rsh_q   <= usr_value << ({2'b00, `RCF_HOST_PBYTES - usr_vlen} * 8);
               ob_q    <= `RCF_DELIM;
               idx_q   <= 16'h0000;
               sum_q   <= 8'h00;
               st_q    <= (fid_q == 8'h00) ? D_IDLE : D_RESP;
            end
            D_RESP: if (out_take) begin
               idx_q <= r_nxt;
               sum_q <= r_sum;
               ob_q  <= rsp_byte(r_nxt, r_sum);
               if (r_nxt >= `RCF_OFF_RVAL && r_nxt < r_last)
                  rsh_q <= rsh_q << 8;
               if (idx_q == r_last)
                  st_q <= D_IDLE;
            end
            default: st_q <= D_IDLE;
         endcase
      end
   end
endmodule : rcf_device
`default_nettype wire

/* File: testbench/rcf_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rcf_link_monitor (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               req_valid,
   input wire logic               req_ready,
   input wire rcf_pkg::rcf_byte_t req_data,
   input wire logic               rsp_valid,
   input wire logic               rsp_ready,
   input wire rcf_pkg::rcf_byte_t rsp_data
);
   import rcf_pkg::*;
   // Byte index, length and running sum per stream
   logic [15:0] qi_q, ql_q, si_q, sl_q;
   rcf_byte_t   qs_q, ss_q, qid_q;
   wire logic qf    = req_valid && req_ready;
   wire logic sf    = rsp_valid && rsp_ready;
   wire logic q_end = qi_q > 16'h0002 && qi_q == ql_q + 16'h0003;
   wire logic s_end = si_q > 16'h0002 && si_q == sl_q + 16'h0003;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {qi_q, ql_q, qs_q, qid_q} <= '0;
      end else if (qf) begin
         qi_q <= q_end ? 16'h0000 : qi_q + 16'h0001;
         qs_q <= (qi_q == 16'h0003) ? req_data : qs_q + req_data;
         if (qi_q == 16'h0001) ql_q[15:8] <= req_data;
         if (qi_q == 16'h0002) ql_q[7:0] <= req_data;
         if (qi_q == 16'h0004) qid_q <= req_data;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {si_q, sl_q, ss_q} <= '0;
      end else if (sf) begin
         si_q <= s_end ? 16'h0000 : si_q + 16'h0001;
         ss_q <= (si_q == 16'h0003) ? rsp_data : ss_q + rsp_data;
         if (si_q == 16'h0001) sl_q[15:8] <= rsp_data;
         if (si_q == 16'h0002) sl_q[7:0] <= rsp_data;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_req_start_byte: assert property (qf && qi_q == 16'h0000 |-> req_data == 8'h7e)
      else $error("request frame lacks start byte");
   chk_req_len_range: assert property (qf && qi_q == 16'h0002 |-> {ql_q[15:8], req_data} inside {[15:19]})
      else $error("request length out of range");
   chk_req_type_code: assert property (qf && qi_q == 16'h0003 |-> req_data == 8'h17)
      else $error("request type wrong");
   chk_req_rsvd_fill: assert property (qf && qi_q inside {16'h000d, 16'h000e} |-> req_data == {7'h7f, qi_q[0]})
      else $error("reserved word not filled");
   chk_req_opt_zero: assert property (qf && qi_q == 16'h000f |-> (req_data & 8'hec) == 8'h00)
      else $error("unused option bits set");
   chk_req_sum_byte: assert property (qf && q_end |-> req_data == 8'hff - qs_q)
      else $error("request checksum wrong");
   chk_rsp_start_byte: assert property (sf && si_q == 16'h0000 |-> rsp_data == 8'h7e)
      else $error("response frame lacks start byte");
   chk_rsp_len_range: assert property (sf && si_q == 16'h0002 |-> {sl_q[15:8], rsp_data} inside {[3:7]})
      else $error("response length out of range");
   chk_rsp_type_code: assert property (sf && si_q == 16'h0003 |-> rsp_data == 8'h97)
      else $error("response type wrong");
   chk_rsp_id_echo: assert property (sf && si_q == 16'h0004 |-> rsp_data == qid_q && qid_q != 8'h00)
      else $error("response id not echoed or sent for id zero");
   chk_rsp_sum_byte: assert property (sf && s_end |-> rsp_data == 8'hff - ss_q)
      else $error("response checksum wrong");
endmodule : rcf_link_monitor
`default_nettype wire

/* File: testbench/remote_command_request_framer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_command_request_framer_tb_top;
   import rcf_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv, usr_done, pw;
   logic        d_val, d_qry, d_nak, d_sec, d_app, d_pend, d_rej, b_val, b_qry, b_drop;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv, usr_value;
   logic [2:0]  usr_vlen;
   logic [63:0] d_dest, d_par;
   logic [15:0] d_cmd, d_plen, b_cmd;
   rcf_byte_t   usr_status, d_fid, d_opt;
   rcf_byte_t   fr [19];
   rcf_byte_t   ot [5] = '{8'h01, 8'h02, 8'h10, 8'h00, 8'hff};
   logic [7:0]  ra [4] = '{8'h04, 8'h08, 8'h0c, 8'h1c};
   logic [31:0] rv [4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_ffff, 32'h0000_0000};
   int          fail_count, checks_done, rejn, dropn;
   rcf_link_if l1 ();
   rcf_link_if l2 ();
   rcf_host u_rcf_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .link(l1));
   rcf_device #(.PMAX(8)) u_rcf_device (.pclk, .presetn, .link(l1), .remote_command_password(pw),
      .req_valid(d_val), .req_fid(d_fid), .req_dest(d_dest), .req_opt(d_opt), .req_cmd(d_cmd),
      .req_param(d_par), .req_plen(d_plen), .req_query(d_qry), .req_no_ack(d_nak), .req_secure(d_sec),
      .req_apply(d_app), .changes_pending(d_pend), .frame_drop(), .frame_reject(d_rej),
      .usr_done, .usr_status, .usr_value, .usr_vlen);
   // Second device faces the bench, which can send broken frames
   rcf_device #(.PMAX(8)) u_rcf_device_b (.pclk, .presetn, .link(l2), .remote_command_password(pw),
      .req_valid(b_val), .req_fid(), .req_dest(), .req_opt(), .req_cmd(b_cmd), .req_param(), .req_plen(),
      .req_query(b_qry), .req_no_ack(), .req_secure(), .req_apply(), .changes_pending(),
      .frame_drop(b_drop), .frame_reject(), .usr_done(1'b0), .usr_status, .usr_value, .usr_vlen);
   rcf_link_monitor u_rcf_link_monitor (.pclk, .presetn, .req_valid(l1.req_valid), .req_ready(l1.req_ready),
      .req_data(l1.req_data), .rsp_valid(l1.rsp_valid), .rsp_ready(l1.rsp_ready), .rsp_data(l1.rsp_data));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (d_rej === 1'b1) rejn++;
      if (b_drop === 1'b1) dropn++;
   end
   task automatic end_sim;
      if (fail_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task automatic tmo;
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      end_sim;
   endtask : tmo
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Starts on an edge so back-to-back calls never assign psel twice at once
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         if (++n > 50) tmo;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic wait_st(input int b, input logic v);
      int n = 0;
      do begin
         apb(1'b0, 8'h1c, 32'h0000_0000, rdv, erv);
         if (++n > 200) tmo;
      end while (rdv[b] !== v);
   endtask : wait_st
   task automatic send2;
      int n = 0;
      @(posedge pclk);
      for (int i = 0; i < 19; i++) begin
         {l2.req_valid, l2.req_data} <= {1'b1, fr[i]};
         do begin
            @(posedge pclk);
            if (++n > 500) tmo;
         end while (l2.req_ready !== 1'b1);
      end
      l2.req_valid <= 1'b0;
   endtask : send2
   function automatic logic exp_pend(input logic p, input rcf_byte_t o, input logic [15:0] c, input int n);
      if (o[1] || c == 16'h4143) return 1'b0;
      return (n != 0) ? 1'b1 : p;
   endfunction : exp_pend
   function automatic rcf_byte_t csum(input int last);
      rcf_byte_t s = 8'h00;
      for (int i = 3; i <= last; i++) s += fr[i];
      return 8'hff - s;
   endfunction : csum
   initial begin
      rcf_byte_t   fid, opt, st;
      logic [63:0] dest;
      logic [31:0] par, val;
      logic [15:0] cmd;
      logic [2:0]  vl;
      int          pl;
      logic        pend;
      {psel, penable, pwrite, paddr, pwdata, presetn, usr_done, usr_status, usr_value, usr_vlen, pw} = '0;
      {l2.req_valid, l2.req_data, l2.rsp_ready} = 10'h001;
      {fail_count, checks_done, rejn, dropn, pend} = '0;
      void'($urandom(32'h65e8));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ra[i], 32'h0000_0000, rdv, erv);
         chk(rdv, rv[i]);
      end
      apb(1'b0, 8'h24, 32'h0000_0000, rdv, erv);
      chk({rdv, erv}, 33'h0_0000_0001);
      for (int i = 0; i < 10; i++) begin
         fid  = (i == 1) ? 8'h00 : 8'($urandom);
         opt  = (i < 5) ? ot[i] : 8'($urandom);
         cmd  = (i == 2) ? 16'h4143 : 16'($urandom);
         pl   = i % 5;
         dest = {$urandom, $urandom};
         {par, val, st} = {$urandom, $urandom, 8'($urandom)};
         vl   = 3'($urandom_range(4, 1));
         apb(1'b1, 8'h04, {24'h0, fid}, rdv, erv);
         apb(1'b1, 8'h08, dest[63:32], rdv, erv);
         apb(1'b1, 8'h0c, dest[31:0], rdv, erv);
         apb(1'b1, 8'h10, {16'h0, cmd}, rdv, erv);
         apb(1'b1, 8'h14, par, rdv, erv);
         apb(1'b1, 8'h18, 32'(pl), rdv, erv);
         apb(1'b1, 8'h00, {16'h0, opt, 8'h01}, rdv, erv);
         for (int n = 0; d_val !== 1'b1; n++) begin
            if (n > 100) tmo;
            @(negedge pclk);
         end
         chk({d_fid, d_dest}, {fid, dest});
         chk({d_opt, d_nak, d_sec}, {opt & 8'h13, opt[0], opt[4]});
         chk({d_cmd, d_plen, d_qry}, {cmd, 16'(pl), pl == 0});
         chk(d_app, opt[1] || cmd == 16'h4143);
         for (int k = 0; k < pl; k++) chk(d_par[k*8 +: 8], par[(pl-1-k)*8 +: 8]);
         @(posedge pclk);
         {usr_done, usr_status, usr_value, usr_vlen} <= {1'b1, st, val, vl};
         @(posedge pclk);
         usr_done <= 1'b0;
         pend = exp_pend(pend, opt, cmd, pl);
         if (fid != 8'h00) begin
            wait_st(1, 1'b1);
            chk({rdv[23:8], rdv[2]}, {st, fid, 1'b0});
            apb(1'b0, 8'h20, 32'h0000_0000, rdv, erv);
            chk(rdv, (vl == 3'h4) ? val : val & ((32'h1 << (8 * vl)) - 32'h1));
            apb(1'b1, 8'h1c, 32'h0000_0006, rdv, erv);
         end else begin
            repeat (40) @(posedge pclk);
            apb(1'b0, 8'h1c, 32'h0000_0000, rdv, erv);
            chk(rdv[1], 1'b0);
         end
         wait_st(0, 1'b0);
         chk(d_pend, pend);
      end
      fr = '{8'h7e, 8'h00, 8'h0f, 8'h17, 8'hfa, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78,
             8'hff, 8'hfe, 8'h00, 8'h54, 8'h50, 8'h00};
      fr[18] = csum(17) + 8'h01;
      send2;
      fr[18] = csum(17);
      fr[2] = 8'h0e;
      send2;
      chk({b_val, 32'(dropn)}, {1'b0, 32'h2});
      fr[2] = 8'h0f;
      send2;
      @(negedge pclk);
      chk({b_val, b_qry, b_cmd}, {2'b11, 16'h5450});
      // Rejected frames get no answer, and pw stays high so later frames would be rejected: run last
      @(posedge pclk);
      pw <= 1'b1;
      apb(1'b1, 8'h04, 32'h0000_0009, rdv, erv);
      apb(1'b1, 8'h00, 32'h0000_0001, rdv, erv);
      repeat (60) @(posedge pclk);
      chk({d_val, 32'(rejn)}, {1'b0, 32'h1});
      end_sim;
   end
   initial begin
      #5_000_000;
      tmo;
   end
endmodule : remote_command_request_framer_tb_top
`default_nettype wire
